// ### hdl/fdq_pkg.sv
package fdq_pkg;
  // Frame descriptor word offsets (bytes from descriptor base)
  localparam logic [31:0] FD_OFF_CONF  = 32'h0000_0000;
  localparam logic [31:0] FD_OFF_RSTAT = 32'h0000_0002;
  localparam logic [31:0] FD_OFF_CTL   = 32'h0000_0004;
  localparam logic [31:0] FD_OFF_NEXT  = 32'h0000_0006;
  localparam logic [31:0] FD_OFF_BD    = 32'h0000_000c;
  localparam logic [31:0] FD_OFF_LEN   = 32'h0000_0010;
  // Buffer descriptor word offsets
  localparam logic [31:0] BD_OFF_CTL   = 32'h0000_0006;
  localparam logic [31:0] BD_OFF_LEN   = 32'h0000_0008;
  localparam logic [31:0] BD_OFF_IND   = 32'h0000_000a;
  localparam logic [31:0] BD_OFF_NEXT  = 32'h0000_000e;
  // A pointer is two words, high half at the lower address
  localparam logic [31:0] PTR_LO       = 32'h0000_0002;
  // Bit positions inside descriptor words
  localparam int CONF_CFD  = 15;
  localparam int CONF_NEG  = 14;
  localparam int CONF_EMP  = 13;
  localparam int CONF_FTL  = 12;
  localparam int CONF_UR   = 11;
  localparam int CTL_NPV   = 15;
  localparam int CTL_WFD   = 14;
  localparam int BD_FINAL_BUFFER_MARK   = 15;
  localparam int BD_WBD    = 15;
  localparam int IND_LAST  = 15;
  localparam logic [15:0] IND_NRV_SET = 16'h8000;
  // Status word 0 bit positions
  localparam int ST_SENT = 0;
  localparam int ST_RECV = 1;
  localparam int ST_UR   = 2;
  localparam int ST_TRANSMIT_QUEUE_END_FLAG = 3;
  localparam int ST_FPE  = 4;
  localparam int ST_FPL  = 5;
  localparam int ST_BPE  = 6;
  localparam int ST_BPL  = 7;
  // Register byte addresses
  localparam logic [7:0] REG_STATUS  = 8'h00;
  localparam logic [7:0] REG_RETRY   = 8'h04;
  localparam logic [7:0] REG_EMASK   = 8'h08;
  localparam logic [7:0] REG_FREE_FD = 8'h0c;
  localparam logic [7:0] REG_FREE_BD = 8'h10;
  localparam logic [7:0] REG_ACTIVE  = 8'h14;
  localparam logic [7:0] REG_TXHEAD  = 8'h20;
  localparam logic [7:0] REG_RXTAIL  = 8'h30;
  // Reset values
  localparam logic [7:0]  RETRY_RST = 8'h00;
  localparam logic [15:0] EMASK_RST = 16'h0000;
  localparam int NQ = 4;

  typedef enum logic [4:0] {
    S_IDLE, T_LEN, T_BDH, T_BDL, T_BLEN, T_BCTL, T_BNH, T_BNL, T_XMIT,
    T_NPV, T_CONF, T_NH, T_NL, R_CTL, R_NH, R_NL, R_BCTL, R_BLEN, R_BIND,
    R_BNH, R_BNL, R_F0, R_F2, R_FCH, R_FCL, R_FLEN, R_T0, R_T6, R_T8
  } fdq_st_t;
endpackage

// ### hdl/fdq_avs.sv
module fdq_avs (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Avalon-MM slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Register file side
  output logic             reg_wr,
  output logic      [7:0]  reg_addr,
  output logic      [31:0] reg_wdata,
  input  wire logic [31:0] reg_rdata
);
  typedef struct packed {
    logic        wreq;
    logic [31:0] rdata;
  } fdq_avs_t;

  fdq_avs_t r, n;

  // Every access answers one cycle after it is seen; waitrequest idles high
  always_comb begin
    n = r;
    n.wreq = 1'b1;
    if ((avs_read || avs_write) && r.wreq) begin
      n.wreq = 1'b0;
      n.rdata = avs_read ? reg_rdata : 32'h0000_0000;
    end
  end

  // The write lands once, in the cycle before waitrequest drops
  assign reg_wr    = avs_write && r.wreq;
  assign reg_addr  = avs_address;
  assign reg_wdata = avs_writedata;
  assign avs_readdata    = r.rdata;
  assign avs_waitrequest = r.wreq;

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '{wreq: 1'b1, rdata: 32'h0000_0000};
    end else begin
      r <= n;
    end
  end
endmodule

// ### hdl/fdq_avm.sv
module fdq_avm (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Request side
  input  wire logic        go,
  input  wire logic        we,
  input  wire logic [31:0] addr,
  input  wire logic [15:0] wdata,
  output logic             done,
  output logic      [15:0] rdata,
  // Avalon-MM master to descriptor memory
  output logic      [31:0] avm_address,
  output logic             avm_read,
  output logic             avm_write,
  output logic      [15:0] avm_writedata,
  input  wire logic [15:0] avm_readdata,
  input  wire logic        avm_waitrequest
);
  typedef struct packed {
    logic [31:0] addr;
    logic        rd;
    logic        wr;
    logic [15:0] wdata;
    logic        done;
    logic [15:0] rdata;
  } fdq_avm_t;

  fdq_avm_t r, n;

  // Request held until waitrequest is seen low, then done pulses once
  always_comb begin
    n = r;
    n.done = 1'b0;
    if ((r.rd || r.wr) && !avm_waitrequest) begin
      n.rd = 1'b0;
      n.wr = 1'b0;
      n.done = 1'b1;
      n.rdata = avm_readdata;
    end else if (go && !r.rd && !r.wr) begin
      n.addr = addr;
      n.rd = !we;
      n.wr = we;
      n.wdata = wdata;
    end
  end

  assign done          = r.done;
  assign rdata         = r.rdata;
  assign avm_address   = r.addr;
  assign avm_read      = r.rd;
  assign avm_write     = r.wr;
  assign avm_writedata = r.wdata;

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule

// ### hdl/fdq_top.sv
// Notes on behaviour
// - End of a transmit queue sets transmit_queue_end_flag, status bit 3.
// - One head pointer per transmit queue; transmission starts from it.
// - Confirmation word: confirm set, negative on failure, drained on last frame.
// - Buffer byte sum above frame length sets negative and too-long flags.
// - Underrun sets descriptor starved flag and status underrun bit.
// - Underrun alone triggers retransmission while retry limit not exceeded.
// - Sent-frame status flag is set as the last transmit step.
// - Last free frame descriptor is retained and its link rechecked per frame.
// - Final free buffer descriptor is never used; mark rechecked per frame.
// - Four receive queues; device updates each tail pointer after reception.
// - Indication bit 15 written zero for taken frame descriptor.
// - Receive status stored; masked error bits discard the frame.
// - Clear link bit flags pool empty yet descriptor used; low mark flags.
// - Final buffer mark skips descriptor, flags empty; indication written per buffer.
// - Set tail more-valid, link new descriptor, move tail, flag reception.
// - Confirm and drained written in one access right after link sampling.
module fdq_top
  import fdq_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Register slave
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Descriptor memory master
  output logic      [31:0] avm_address,
  output logic             avm_read,
  output logic             avm_write,
  output logic      [15:0] avm_writedata,
  input  wire logic [15:0] avm_readdata,
  input  wire logic        avm_waitrequest,
  // Transmit link
  output logic             tx_go,
  output logic      [31:0] tx_fd,
  output logic      [1:0]  tx_prio,
  input  wire logic        tx_done,
  input  wire logic        tx_underrun,
  // Receive link
  input  wire logic        rx_valid,
  output logic             rx_ready,
  input  wire logic [1:0]  rx_prio,
  input  wire logic [15:0] rx_len,
  input  wire logic [15:0] rx_status
);
  import fdq_pkg::*;

  typedef struct packed {
    fdq_st_t            state;
    logic               pend;
    logic [NQ-1:0][31:0] head;
    logic [NQ-1:0][31:0] tail;
    logic [NQ-1:0]      act;
    logic [31:0]        free_fd;
    logic [31:0]        free_bd;
    logic               held;
    logic [31:0]        fd;
    logic [31:0]        bd;
    logic [31:0]        first_bd;
    logic [31:0]        nxt;
    logic [31:0]        nfd;
    logic [1:0]         q;
    logic [15:0]        flen;
    logic [16:0]        sum;
    logic [15:0]        rem;
    logic [14:0]        blen;
    logic               next_link_valid;
    logic               ur;
    logic               fail;
    logic               txw;
    logic [7:0]         retry;
    logic               got_bd;
    logic               lastbd;
    logic [15:0]        rstat;
    logic [7:0]         sts;
    logic [7:0]         rlim;
    logic [15:0]        emask;
    logic               tx_go;
    logic               rx_rdy;
  } fdq_top_t;

  fdq_top_t r, n;

  logic        s_wr;
  logic [7:0]  s_addr;
  logic [31:0] s_wdata;
  logic [31:0] s_rdata;
  logic        m_go;
  logic        m_we;
  logic [31:0] m_addr;
  logic [15:0] m_wdata;
  logic        m_done;
  logic [15:0] m_rdata;
  logic [7:0]  st_set;
  logic [7:0]  st_clr;
  logic [1:0]  pick;
  logic [15:0] used;
  logic        blast;
  logic        frame_too_long_flag;

  // States that own a descriptor memory cycle
  function automatic logic is_mem(input fdq_st_t s);
    return !(s == S_IDLE || s == T_XMIT);
  endfunction

  fdq_avs u_avs (
    .clk             (clk),
    .rst             (rst),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .reg_wr          (s_wr),
    .reg_addr        (s_addr),
    .reg_wdata       (s_wdata),
    .reg_rdata       (s_rdata)
  );

  fdq_avm u_avm (
    .clk             (clk),
    .rst             (rst),
    .go              (m_go),
    .we              (m_we),
    .addr            (m_addr),
    .wdata           (m_wdata),
    .done            (m_done),
    .rdata           (m_rdata),
    .avm_address     (avm_address),
    .avm_read        (avm_read),
    .avm_write       (avm_write),
    .avm_writedata   (avm_writedata),
    .avm_readdata    (avm_readdata),
    .avm_waitrequest (avm_waitrequest)
  );

  // Register read mux; unmapped addresses read zero
  always_comb begin
    s_rdata = 32'h0000_0000;
    unique case (s_addr)
      REG_STATUS:  s_rdata = {24'h00_0000, r.sts};
      REG_RETRY:   s_rdata = {24'h00_0000, r.rlim};
      REG_EMASK:   s_rdata = {16'h0000, r.emask};
      REG_FREE_FD: s_rdata = r.free_fd;
      REG_FREE_BD: s_rdata = r.free_bd;
      REG_ACTIVE:  s_rdata = {28'h000_0000, r.act};
      default: begin
        for (int i = 0; i < NQ; i++) begin
          if (s_addr == 8'(REG_TXHEAD + 4 * i)) s_rdata = r.head[i];
          if (s_addr == 8'(REG_RXTAIL + 4 * i)) s_rdata = r.tail[i];
        end
      end
    endcase
  end

  // Highest active transmit priority wins
  always_comb begin
    pick = 2'h0;
    for (int i = 0; i < NQ; i++) begin
      if (r.act[i]) pick = 2'(i);
    end
  end

  // Buffer fill: take what still fits; last when the frame ends here
  assign used  = ({1'b0, r.blen} < r.rem) ? {1'b0, r.blen} : r.rem;
  assign blast = r.rem <= {1'b0, r.blen};
  assign frame_too_long_flag   = r.sum > {1'b0, r.flen};

  // One memory cycle per descriptor word
  assign m_go = !r.pend && is_mem(r.state);

  always_comb begin
    n = r;
    n.tx_go = 1'b0;
    st_set = 8'h00;
    st_clr = 8'h00;
    m_we = 1'b0;
    m_addr = 32'h0000_0000;
    m_wdata = 16'h0000;
    if (m_go) n.pend = 1'b1;
    else if (m_done) n.pend = 1'b0;
    // Software writes; a head write is the start command
    if (s_wr) begin
      unique case (s_addr)
        REG_STATUS:  st_clr = s_wdata[7:0];
        REG_RETRY:   n.rlim = s_wdata[7:0];
        REG_EMASK:   n.emask = s_wdata[15:0];
        REG_FREE_FD: begin
          n.free_fd = s_wdata;
          n.held = 1'b0;
        end
        REG_FREE_BD: n.free_bd = s_wdata;
        default: begin
          for (int i = 0; i < NQ; i++) begin
            if (s_addr == 8'(REG_TXHEAD + 4 * i)) begin
              n.head[i] = s_wdata;
              n.act[i] = 1'b1;
            end
            if (s_addr == 8'(REG_RXTAIL + 4 * i)) n.tail[i] = s_wdata;
          end
        end
      endcase
    end
    unique case (r.state)
      S_IDLE: begin
        n.rx_rdy = 1'b1;
        if (rx_valid && r.rx_rdy) begin
          n.q = rx_prio;
          n.rem = rx_len;
          n.flen = rx_len;
          n.rstat = rx_status;
          n.fd = r.free_fd;
          n.bd = r.free_bd;
          n.got_bd = 1'b0;
          // Frames with masked error bits are dropped untouched
          if ((rx_status & r.emask) == 16'h0000) begin
            n.rx_rdy = 1'b0;
            n.state = R_CTL;
          end
        end else if (|r.act) begin
          n.rx_rdy = 1'b0;
          n.q = pick;
          n.fd = r.head[pick];
          n.sum = 17'h0_0000;
          n.ur = 1'b0;
          n.fail = 1'b0;
          n.retry = 8'h00;
          n.state = T_LEN;
        end
      end
      // Transmit: gather length and walk buffers to sum their bytes
      T_LEN: begin
        m_addr = r.fd + FD_OFF_LEN;
        if (m_done) begin
          n.flen = m_rdata;
          n.state = T_BDH;
        end
      end
      T_BDH: begin
        m_addr = r.fd + FD_OFF_BD;
        if (m_done) begin
          n.nxt[31:16] = m_rdata;
          n.state = T_BDL;
        end
      end
      T_BDL: begin
        m_addr = r.fd + FD_OFF_BD + PTR_LO;
        if (m_done) begin
          n.bd = {r.nxt[31:16], m_rdata};
          n.state = T_BLEN;
        end
      end
      T_BLEN: begin
        m_addr = r.bd + BD_OFF_LEN;
        if (m_done) begin
          n.sum = r.sum + {2'b00, m_rdata[14:0]};
          n.state = T_BCTL;
        end
      end
      T_BCTL: begin
        m_addr = r.bd + BD_OFF_CTL;
        if (m_done) n.state = m_rdata[BD_FINAL_BUFFER_MARK] ? T_XMIT : T_BNH;
      end
      T_BNH: begin
        m_addr = r.bd + BD_OFF_NEXT;
        if (m_done) begin
          n.nxt[31:16] = m_rdata;
          n.state = T_BNL;
        end
      end
      T_BNL: begin
        m_addr = r.bd + BD_OFF_NEXT + PTR_LO;
        if (m_done) begin
          n.bd = {r.nxt[31:16], m_rdata};
          n.state = T_BLEN;
        end
      end
      // Hand the frame to the link; only an underrun earns another try
      T_XMIT: begin
        if (!r.txw) begin
          n.tx_go = 1'b1;
          n.txw = 1'b1;
        end else if (tx_done) begin
          n.txw = 1'b0;
          n.fail = 1'b0;
          if (tx_underrun) begin
            n.ur = 1'b1;
            st_set[ST_UR] = 1'b1;
            if (r.retry < r.rlim) n.retry = r.retry + 8'h01;
            else begin
              n.fail = 1'b1;
              n.state = T_NPV;
            end
          end else begin
            n.state = T_NPV;
          end
        end
      end
      T_NPV: begin
        m_addr = r.fd + FD_OFF_CTL;
        if (m_done) begin
          n.next_link_valid = m_rdata[CTL_NPV];
          n.state = T_CONF;
        end
      end
      // Confirm and drained go out together right after the link sample
      T_CONF: begin
        m_we = 1'b1;
        m_addr = r.fd + FD_OFF_CONF;
        m_wdata[CONF_CFD] = 1'b1;
        m_wdata[CONF_NEG] = r.fail || frame_too_long_flag;
        m_wdata[CONF_EMP] = !r.next_link_valid;
        m_wdata[CONF_FTL] = frame_too_long_flag;
        m_wdata[CONF_UR] = r.ur;
        if (m_done) begin
          if (r.next_link_valid) n.state = T_NH;
          else begin
            n.act[r.q] = 1'b0;
            st_set[ST_TRANSMIT_QUEUE_END_FLAG] = 1'b1;
            st_set[ST_SENT] = 1'b1;
            n.state = S_IDLE;
          end
        end
      end
      T_NH: begin
        m_addr = r.fd + FD_OFF_NEXT;
        if (m_done) begin
          n.nxt[31:16] = m_rdata;
          n.state = T_NL;
        end
      end
      T_NL: begin
        m_addr = r.fd + FD_OFF_NEXT + PTR_LO;
        if (m_done) begin
          n.head[r.q] = {r.nxt[31:16], m_rdata};
          st_set[ST_SENT] = 1'b1;
          n.state = S_IDLE;
        end
      end
      // Receive: sample the free descriptor's link and low mark
      R_CTL: begin
        m_addr = r.fd + FD_OFF_CTL;
        if (m_done) begin
          n.next_link_valid = m_rdata[CTL_NPV];
          if (r.held) begin
            // Retained descriptor already used; follow its link if refilled
            if (m_rdata[CTL_NPV]) n.state = R_NH;
            else begin
              st_set[ST_FPE] = 1'b1;
              n.state = S_IDLE;
            end
          end else begin
            st_set[ST_FPE] = !m_rdata[CTL_NPV];
            st_set[ST_FPL] = m_rdata[CTL_WFD];
            if (m_rdata[CTL_NPV]) n.state = R_NH;
            else n.state = (r.rem != 16'h0000) ? R_BCTL : R_F0;
          end
        end
      end
      R_NH: begin
        m_addr = r.fd + FD_OFF_NEXT;
        if (m_done) begin
          n.nfd[31:16] = m_rdata;
          n.state = R_NL;
        end
      end
      R_NL: begin
        m_addr = r.fd + FD_OFF_NEXT + PTR_LO;
        if (m_done) begin
          n.nfd[15:0] = m_rdata;
          if (r.held) begin
            n.fd = {r.nfd[31:16], m_rdata};
            n.held = 1'b0;
            n.state = R_CTL;
          end else begin
            n.state = (r.rem != 16'h0000) ? R_BCTL : R_F0;
          end
        end
      end
      R_BCTL: begin
        m_addr = r.bd + BD_OFF_CTL;
        if (m_done) begin
          if (m_rdata[BD_FINAL_BUFFER_MARK]) begin
            st_set[ST_BPE] = 1'b1;
            n.state = R_F0;
          end else begin
            n.state = R_BLEN;
          end
        end
      end
      R_BLEN: begin
        m_addr = r.bd + BD_OFF_LEN;
        if (m_done) begin
          n.blen = m_rdata[14:0];
          st_set[ST_BPL] = m_rdata[BD_WBD];
          n.state = R_BIND;
        end
      end
      R_BIND: begin
        m_we = 1'b1;
        m_addr = r.bd + BD_OFF_IND;
        m_wdata = {blast, 15'({1'b0, r.blen} - used)};
        if (m_done) begin
          if (!r.got_bd) n.first_bd = r.bd;
          n.got_bd = 1'b1;
          n.rem = r.rem - used;
          n.lastbd = blast;
          n.state = R_BNH;
        end
      end
      R_BNH: begin
        m_addr = r.bd + BD_OFF_NEXT;
        if (m_done) begin
          n.nxt[31:16] = m_rdata;
          n.state = R_BNL;
        end
      end
      R_BNL: begin
        m_addr = r.bd + BD_OFF_NEXT + PTR_LO;
        if (m_done) begin
          n.bd = {r.nxt[31:16], m_rdata};
          n.state = r.lastbd ? R_F0 : R_BCTL;
        end
      end
      // New descriptor becomes the queue's last: more-valid written zero
      R_F0: begin
        m_we = 1'b1;
        m_addr = r.fd + FD_OFF_CONF;
        m_wdata = 16'h0000;
        if (m_done) begin
          n.free_bd = r.bd;
          n.state = R_F2;
        end
      end
      R_F2: begin
        m_we = 1'b1;
        m_addr = r.fd + FD_OFF_RSTAT;
        m_wdata = r.rstat;
        if (m_done) n.state = r.got_bd ? R_FCH : R_FLEN;
      end
      R_FCH: begin
        m_we = 1'b1;
        m_addr = r.fd + FD_OFF_BD;
        m_wdata = r.first_bd[31:16];
        if (m_done) n.state = R_FCL;
      end
      R_FCL: begin
        m_we = 1'b1;
        m_addr = r.fd + FD_OFF_BD + PTR_LO;
        m_wdata = r.first_bd[15:0];
        if (m_done) n.state = R_FLEN;
      end
      R_FLEN: begin
        m_we = 1'b1;
        m_addr = r.fd + FD_OFF_LEN;
        m_wdata = r.flen;
        if (m_done) n.state = R_T0;
      end
      // Link behind the old tail, then move the tail and report
      R_T0: begin
        m_we = 1'b1;
        m_addr = r.tail[r.q] + FD_OFF_CONF;
        m_wdata = IND_NRV_SET;
        if (m_done) n.state = R_T6;
      end
      R_T6: begin
        m_we = 1'b1;
        m_addr = r.tail[r.q] + FD_OFF_NEXT;
        m_wdata = r.fd[31:16];
        if (m_done) n.state = R_T8;
      end
      R_T8: begin
        m_we = 1'b1;
        m_addr = r.tail[r.q] + FD_OFF_NEXT + PTR_LO;
        m_wdata = r.fd[15:0];
        if (m_done) begin
          n.tail[r.q] = r.fd;
          n.free_fd = r.next_link_valid ? r.nfd : r.fd;
          n.held = !r.next_link_valid;
          st_set[ST_RECV] = 1'b1;
          n.state = S_IDLE;
        end
      end
    endcase
    // Hardware set wins over a software clear in the same cycle
    n.sts = (r.sts & ~st_clr) | st_set;
  end

  assign tx_go    = r.tx_go;
  assign tx_fd    = r.fd;
  assign tx_prio  = r.q;
  assign rx_ready = r.rx_rdy;

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
      r.state <= S_IDLE;
      r.rlim <= RETRY_RST;
      r.emask <= EMASK_RST;
    end else begin
      r <= n;
    end
  end
endmodule

// ### test/fdq_top_assertions.sv
module fdq_chk (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Watched ports
  input wire logic [31:0] avm_address,
  input wire logic        avm_read,
  input wire logic        avm_write,
  input wire logic        avm_waitrequest,
  input wire logic        tx_go,
  input wire logic [31:0] tx_fd,
  input wire logic [1:0]  tx_prio,
  input wire logic        tx_done,
  input wire logic        tx_underrun,
  input wire logic        rx_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Memory cycles run one at a time and hold until answered
  a_no_overlap: assert property (!(avm_read && avm_write))
    else $error("read and write together");
  a_rd_held: assert property (avm_read && avm_waitrequest |=>
    avm_read && $stable(avm_address)) else $error("read not held");
  a_wr_held: assert property (avm_write && avm_waitrequest |=>
    avm_write && $stable(avm_address)) else $error("write not held");
  a_req_drop: assert property ((avm_read || avm_write) && !avm_waitrequest |=>
    !avm_read && !avm_write) else $error("request kept");
  // Transmit request is a pulse naming a stable descriptor
  a_go_single: assert property (tx_go |=> !tx_go)
    else $error("go too long");
  a_fd_stable: assert property (tx_go |=> $stable(tx_fd) && $stable(tx_prio))
    else $error("head moved");
  a_no_retry: assert property (tx_done && !tx_underrun |=> !tx_go [*3])
    else $error("retry without underrun");
  a_ready_idle: assert property (rx_ready |-> !avm_read && !avm_write)
    else $error("ready while busy");
  c_retry: cover property (tx_done && tx_underrun);
  c_taken: cover property ($fell(rx_ready));
  c_write: cover property (avm_write && !avm_waitrequest);
endmodule

bind fdq_top fdq_chk i_chk (.*);

// ### test/fdq_mem.sv
module fdq_mem (
  // Clock
  input  wire logic        clk,
  // Descriptor memory slave
  input  wire logic [31:0] avm_address,
  input  wire logic        avm_read,
  input  wire logic        avm_write,
  input  wire logic [15:0] avm_writedata,
  output logic      [15:0] avm_readdata,
  output logic             avm_waitrequest
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [logic [31:0]];
  logic [1:0]  cnt = 2'h0;
  initial avm_readdata = 16'h0000;
  initial avm_waitrequest = 1'b1;
  // Delay of 0..3 cycles by address mixes prompt and slow replies;
  // read data toggles outside answers so stale data never looks valid
  always @(posedge clk) begin
    avm_waitrequest <= 1'b1;
    avm_readdata    <= ~avm_readdata;
    if ((avm_read || avm_write) && avm_waitrequest) begin
      cnt <= cnt + 2'h1;
      if (cnt == avm_address[3:2]) begin
        cnt             <= 2'h0;
        avm_waitrequest <= 1'b0;
        if (avm_write) mem[avm_address] = avm_writedata;
        else avm_readdata <= mem.exists(avm_address) ? mem[avm_address] : 16'h0000;
      end
    end
  end
endmodule

// ### test/fdq_top_tb.sv
module fdq_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import fdq_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, rx_valid = 1'b0;
  logic        tx_done = 1'b0, tx_underrun = 1'b0, tx_go, rx_ready, avs_waitrequest;
  logic        avm_read, avm_write, avm_waitrequest;
  logic [1:0]  tx_prio, rx_prio = 2'h0;
  logic [7:0]  avs_address = 8'h00;
  logic [15:0] avm_writedata, avm_readdata, rx_len = 16'h0000, rx_status = 16'h0000, flen;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, avm_address, tx_fd, rd;
  int          miscompares = 0, num_checks = 0, cyc = 0, seed = 32'h7faa;
  // Clock, design and descriptor memory
  always #20 clk = ~clk;
  fdq_top i_dut (.*);
  fdq_mem i_mem (.*);
  // Cut a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Register access; held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  // Far transmitter: one attempt, ending after a random delay
  task automatic tx_att(input logic ur);
    do @(posedge clk); while (tx_go !== 1'b1);
    chk(tx_fd, 32'h100);
    chk({30'h0, tx_prio}, 32'h2);
    repeat (($random(seed) & 7) + 1) @(posedge clk);
    tx_done     <= 1'b1;
    tx_underrun <= ur;
    @(posedge clk);
    tx_done <= 1'b0;
  endtask
  // Confirmation after a starved first try: too-long adds negative
  function automatic logic [31:0] conf_exp(input logic [15:0] len);
    return 32'ha800 | ((len < 16'h0008) ? 32'h5000 : 32'h0);
  endfunction
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    flen = 16'($random(seed)) & 16'h000f;
    i_mem.mem[32'h10e] = 16'h0200;  // Frame with link bit clear, one buffer
    i_mem.mem[32'h110] = flen;
    i_mem.mem[32'h206] = 16'h8000;
    i_mem.mem[32'h208] = 16'h0008;
    i_mem.mem[32'h304] = 16'h0000;  // Lone pool frame, no low mark
    i_mem.mem[32'h408] = 16'h8006;  // One six-byte buffer with low mark, then the final one
    i_mem.mem[32'h410] = 16'h0700;
    i_mem.mem[32'h706] = 16'h8000;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // Reset values and an unmapped place read as zero
    bus(1'b0, REG_STATUS, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, REG_EMASK, 32'h0);
    chk(rd, {16'h0, EMASK_RST});
    bus(1'b0, REG_RETRY, 32'h0);
    chk(rd, {24'h0, RETRY_RST});
    bus(1'b0, 8'hfc, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, REG_RETRY, 32'h1);
    bus(1'b0, REG_RETRY, 32'h0);
    chk(rd, 32'h1);
    // Start queue 2; starved try, then retry succeeds
    bus(1'b1, REG_TXHEAD + 8'h08, 32'h100);
    tx_att(1'b1);
    tx_att(1'b0);
    rd = 32'h0;
    while (rd[ST_SENT] !== 1'b1) bus(1'b0, REG_STATUS, 32'h0);
    chk(rd, 32'hd);
    chk({16'h0, i_mem.mem[32'h100]}, conf_exp(flen));
    bus(1'b1, REG_STATUS, 32'hff);
    bus(1'b0, REG_STATUS, 32'h0);
    chk(rd, 32'h0);
    // Drained on confirm: host clears the word and restarts the queue
    if (i_mem.mem[32'h100][CONF_EMP]) begin
      i_mem.mem[32'h100] = 16'h0000;
      bus(1'b1, REG_TXHEAD + 8'h08, 32'h100);
      tx_att(1'b0);
      while (rd[ST_SENT] !== 1'b1) bus(1'b0, REG_STATUS, 32'h0);
      chk(rd, 32'h9);
      chk({16'h0, i_mem.mem[32'h100]}, conf_exp(flen) & 32'hf7ff);
    end
    // Receive on queue 1 from a pool whose only frame has no link
    bus(1'b1, REG_FREE_FD, 32'h300);
    bus(1'b1, REG_FREE_BD, 32'h400);
    bus(1'b1, REG_RXTAIL + 8'h04, 32'h500);
    rx_status <= 16'($random(seed));
    rx_prio   <= 2'h1;
    rx_valid  <= 1'b1;
    do @(posedge clk); while (rx_ready !== 1'b1);
    rx_valid <= 1'b0;
    rd = 32'h0;
    while (rd[ST_RECV] !== 1'b1) bus(1'b0, REG_STATUS, 32'h0);
    chk(rd & 32'h12, 32'h12);
    chk({16'h0, i_mem.mem[32'h300]}, 32'h0);
    chk({16'h0, i_mem.mem[32'h302]}, {16'h0, rx_status});
    chk({16'h0, i_mem.mem[32'h500]}, 32'h8000);
    chk({i_mem.mem[32'h506], i_mem.mem[32'h508]}, 32'h300);
    bus(1'b0, REG_RXTAIL + 8'h04, 32'h0);
    chk(rd, 32'h300);
    // Host refills the pool behind the retained descriptor; a four-byte frame follows
    i_mem.mem[32'h308] = 16'h0600;
    i_mem.mem[32'h304] = 16'h8000;
    bus(1'b1, REG_STATUS, 32'hff);
    rx_len   <= 16'h0004;
    rx_valid <= 1'b1;
    do @(posedge clk); while (rx_ready !== 1'b1);
    rx_valid <= 1'b0;
    rd = 32'h0;
    while (rd[ST_RECV] !== 1'b1) bus(1'b0, REG_STATUS, 32'h0);
    chk(rd, 32'h92);
    chk({16'h0, i_mem.mem[32'h40a]}, 32'h8002);
    chk({16'h0, i_mem.mem[32'h300]}, 32'h8000);
    chk({i_mem.mem[32'h60c], i_mem.mem[32'h60e]}, 32'h400);
    bus(1'b0, REG_FREE_BD, 32'h0);
    chk(rd, 32'h700);
    summarize();
  end
endmodule
